// [rtl/urct_pkg.sv]
package urct_pkg;

	// ************************************************************
	// Instances and widths
	// ************************************************************
	localparam int unsigned NUM_TMR    = 3;
	localparam int unsigned CNT_W      = 16;
	localparam int unsigned APB_AW     = 12;
	localparam int unsigned APB_DW     = 32;

	// Only the first and third instance own a toggle output
	localparam logic [2:0]  TOGGLE_MASK = 3'b101;
	// Pin group per instance: first and second share group 0
	localparam logic [2:0]  PIN_GROUP   = 3'b100;

	// ************************************************************
	// Register indices (byte address = page * PAGE_STRIDE + 4 * index)
	// ************************************************************
	localparam logic [7:0]  IDX_CTRL     = 8'hc8;
	localparam logic [7:0]  IDX_CFG      = 8'hc9;
	localparam logic [7:0]  IDX_RLD_LO   = 8'hca;
	localparam logic [7:0]  IDX_RLD_HI   = 8'hcb;
	localparam logic [7:0]  IDX_CNT_LO   = 8'hcc;
	localparam logic [7:0]  IDX_CNT_HI   = 8'hcd;
	localparam logic [11:0] PAGE_STRIDE  = 12'h400;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int unsigned CTRL_TF_POS   = 7;
	localparam int unsigned CTRL_EXF_POS  = 6;
	localparam int unsigned CTRL_EXEN_POS = 3;
	localparam int unsigned CTRL_TR_POS   = 2;
	localparam int unsigned CTRL_CT_POS   = 1;
	localparam int unsigned CTRL_CPRL_POS = 0;
	localparam int unsigned CFG_MODE_POS  = 3;
	localparam int unsigned CFG_TOG_POS   = 2;
	localparam int unsigned CFG_OE_POS    = 1;
	localparam int unsigned CFG_DCEN_POS  = 0;

	// ************************************************************
	// Reset values and count limits
	// ************************************************************
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  CFG_RST  = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] RLD_RST  = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hffff;
	localparam logic [15:0] CNT_MIN  = 16'h0000;

	// ************************************************************
	// Prescale counts
	// ************************************************************
	localparam int unsigned DIV_SYS2  = 2;
	localparam int unsigned DIV_SYS12 = 12;
	localparam int unsigned DIV_EXT8  = 8;

	typedef enum logic [1:0]
	{
		CLK_SYS_DIV12 = 2'b00,
		CLK_SYS       = 2'b01,
		CLK_EXT_DIV8  = 2'b10,
		CLK_SYS_DIV2  = 2'b11
	} urct_clk_mode_e;

	typedef struct packed
	{
		logic tf;
		logic exf;
		logic [1:0] rsv;
		logic exen;
		logic tr;
		logic ct;
		logic cprl;
	} urct_ctrl_s;

	typedef struct packed
	{
		logic [2:0] rsv;
		urct_clk_mode_e mode;
		logic tog;
		logic oe;
		logic dcen;
	} urct_cfg_s;

	typedef struct packed
	{
		logic div2;
		logic div12;
		logic ext8;
	} urct_ticks_s;

endpackage : urct_pkg

// [rtl/urct_prescale.sv]
`timescale 1ns/1ps
module urct_prescale (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ext_osc_clk,
	output urct_pkg::urct_ticks_s     ticks
);
	import urct_pkg::*;

	logic       ext_s;
	logic       ext_prev_q;
	logic [3:0] div12_q;
	logic       div2_q;
	logic [2:0] ext8_q;

	// External oscillator is sampled, so it must not exceed half the system clock
	urct_sync #(.W(1)) u_ext_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_osc_clk),
		.sync_out (ext_s)
	);

	wire ext_rise = ext_s & ~ext_prev_q;
	wire div12_end = (div12_q == 4'(DIV_SYS12 - 1));
	wire ext8_end  = (ext8_q == 3'(DIV_EXT8 - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_prev_q <= 1'b0;
			div12_q    <= 4'h0;
			div2_q     <= 1'b0;
			ext8_q     <= 3'h0;
		end
		else
		begin
			ext_prev_q <= ext_s;
			div12_q    <= div12_end ? 4'h0 : div12_q + 4'h1;
			div2_q     <= ~div2_q;
			if (ext_rise)
				ext8_q <= ext8_end ? 3'h0 : ext8_q + 3'h1;
		end
	end

	// Free-running prescaler shared by all instances
	assign ticks.div2  = div2_q;
	assign ticks.div12 = div12_end;
	assign ticks.ext8  = ext_rise & ext8_end;

endmodule : urct_prescale

// [rtl/urct_sync.sv]
`timescale 1ns/1ps
module urct_sync #(
	parameter int unsigned W = 1
)(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	if (W < 1)
	begin : g_bad_width
		$error("urct_sync width must be at least one");
	end

	// Second stage only reads the first; nothing else taps it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : urct_sync

// [rtl/urct_top.sv]
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module urct_top #(
	parameter int unsigned N_TMR = urct_pkg::NUM_TMR
)(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [urct_pkg::APB_AW-1:0]   paddr,
	input  wire logic [urct_pkg::APB_DW-1:0]   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [urct_pkg::APB_DW-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          ext_osc_clk,
	input  wire logic [1:0]                    count_input_pin,
	input  wire logic [1:0]                    external_trigger_pin,
	output logic      [2:0]                    toggle_out,
	output logic      [2:0]                    toggle_out_oe,
	output logic      [2:0]                    overflow_evt,
	output logic      [2:0]                    timer_irq_req
);
	import urct_pkg::*;

	// Port widths and the pin grouping are laid out for three timers only
	if (N_TMR != NUM_TMR)
	begin : g_bad_count
		$error("urct_top supports exactly three timer instances");
	end

	// Byte registers and the wrap compares assume a 16-bit count
	if (CNT_W != 16)
	begin : g_bad_width
		$error("urct_top needs a 16-bit count");
	end

	// ************************************************************
	// Pin synchronisation and edge detection
	// ************************************************************
	logic [1:0] cnt_pin_s;
	logic [1:0] trg_pin_s;
	logic [1:0] cnt_pin_prev_q;
	logic [1:0] trg_pin_prev_q;
	urct_ticks_s ticks;

	// Group 0 pins feed the first two timers alike
	urct_sync #(.W(4)) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({count_input_pin, external_trigger_pin}),
		.sync_out ({cnt_pin_s, trg_pin_s})
	);

	// ************************************************************
	// Shared prescaler
	// ************************************************************
	urct_prescale u_prescale (
		.pclk        (pclk),
		.presetn     (presetn),
		.ext_osc_clk (ext_osc_clk),
		.ticks       (ticks)
	);

	// ************************************************************
	// Falling-edge detection
	// ************************************************************
	// Edge flops reset low, so a pin held high out of reset never fakes a falling edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_pin_prev_q <= 2'b00;
		else
			cnt_pin_prev_q <= cnt_pin_s;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trg_pin_prev_q <= 2'b00;
		else
			trg_pin_prev_q <= trg_pin_s;
	end

	// One event per falling edge, taken after the synchroniser
	wire [1:0] cnt_fall = cnt_pin_prev_q & ~cnt_pin_s;
	wire [1:0] trg_fall = trg_pin_prev_q & ~trg_pin_s;

	// ************************************************************
	// APB decode
	// ************************************************************
	wire [1:0] acc_page = paddr[11:10];
	wire [7:0] acc_idx  = paddr[9:2];
	wire       idx_ok   = (acc_idx >= IDX_CTRL) && (acc_idx <= IDX_CNT_HI);
	wire       page_ok  = (32'(acc_page) < N_TMR);
	wire       addr_ok  = idx_ok & page_ok;
	wire       apb_wr   = psel & penable & pwrite & addr_ok & pstrb[0];
	wire       apb_setup = psel & ~penable;

	// Read data is latched in setup so the access phase completes at once
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// ************************************************************
	// Read data
	// ************************************************************
	logic [7:0] rd_byte [3];

	// Page 3 is not mapped, so it never selects a timer and reads as zero
	wire [7:0]        rd_sel  = page_ok ? rd_byte[acc_page] : 8'h00;
	wire [APB_DW-1:0] rd_word = (addr_ok & ~pwrite) ? {24'h000000, rd_sel} : '0;

	// Bytes are taken one at a time; software must allow for a carry between them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (apb_setup)
			prdata <= rd_word;
	end

	// ************************************************************
	// Timer instances
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_tmr
			localparam int unsigned PG = int'(PIN_GROUP[gi]);
			localparam logic HAS_TOG = TOGGLE_MASK[gi];

			// ************************************************************
			// Timer state
			// ************************************************************
			urct_ctrl_s  ctrl_q;
			urct_ctrl_s  ctrl_d;
			urct_cfg_s   cfg_q;
			urct_cfg_s   cfg_d;
			logic [15:0] cnt_q;
			logic [15:0] cnt_d;
			logic [15:0] rld_q;
			logic [15:0] rld_d;
			logic        evt_q;
			logic        exf_req_q;
			logic        exf_req_d;

			// ************************************************************
			// Register write decode
			// ************************************************************
			wire wr_me   = apb_wr & (acc_page == 2'(gi));
			wire wr_ctrl = wr_me & (acc_idx == IDX_CTRL);
			wire wr_cfg  = wr_me & (acc_idx == IDX_CFG);
			wire wr_rl   = wr_me & (acc_idx == IDX_RLD_LO);
			wire wr_rh   = wr_me & (acc_idx == IDX_RLD_HI);
			wire wr_cl   = wr_me & (acc_idx == IDX_CNT_LO);
			wire wr_ch   = wr_me & (acc_idx == IDX_CNT_HI);
			wire [7:0] wb = pwdata[7:0];

			// ************************************************************
			// Count events
			// ************************************************************
			// Clock source select
			wire sel_div12 = (cfg_q.mode == CLK_SYS_DIV12);
			wire sel_sys   = (cfg_q.mode == CLK_SYS);
			wire sel_ext8  = (cfg_q.mode == CLK_EXT_DIV8);
			wire sel_div2  = (cfg_q.mode == CLK_SYS_DIV2);
			wire clk_tick  = (sel_div12 & ticks.div12) | sel_sys | (sel_ext8 & ticks.ext8) | (sel_div2 & ticks.div2);
			// Counter function counts pin falling edges
			wire src_tick = ctrl_q.ct ? cnt_fall[PG] : clk_tick;
			wire step     = ctrl_q.tr & src_tick;
			// Direction follows trigger level only with decrement enabled
			wire up       = ~cfg_q.dcen | trg_pin_s[PG];
			// Trigger edges are direction-only while decrementing is enabled
			wire trg_evt  = ctrl_q.exen & ~cfg_q.dcen & trg_fall[PG];
			wire cap_mode = ctrl_q.cprl;

			wire at_max   = (cnt_q == CNT_MAX);
			wire at_min   = (cnt_q == CNT_MIN);
			wire at_rld   = (cnt_q == rld_q);
			// Capture underflow at zero, reload underflow at the reload value
			wire dn_wrap  = cap_mode ? at_min : at_rld;
			wire wrap     = step & (up ? at_max : dn_wrap);
			wire capture  = trg_evt & cap_mode;
			wire ext_rld  = trg_evt & ~cap_mode;
			// A trigger event, or software in capture mode, raises the external request;
			// the reload-mode wrap toggling of the flag never does
			wire exf_clr  = wr_ctrl & ~wb[CTRL_EXF_POS];
			wire exf_set  = capture | ext_rld | (wr_ctrl & wb[CTRL_EXF_POS] & cap_mode);
			assign exf_req_d = exf_set | (exf_req_q & ~exf_clr);

			// ************************************************************
			// Next state
			// ************************************************************
			// Count next value; a software byte write wins over counting
			always_comb
			begin
				cnt_d = cnt_q;
				if (ext_rld)
					cnt_d = rld_q;
				else if (wrap & ~cap_mode)
					cnt_d = up ? rld_q : CNT_MAX;
				else if (step)
					cnt_d = up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
				if (wr_cl)
					cnt_d[7:0] = wb;
				if (wr_ch)
					cnt_d[15:8] = wb;
			end

			always_comb
			begin
				rld_d = rld_q;
				if (capture)
					rld_d = cnt_q;
				if (wr_rl)
					rld_d[7:0] = wb;
				if (wr_rh)
					rld_d[15:8] = wb;
			end

			// Hardware sets win over a software clear in the same cycle
			always_comb
			begin
				ctrl_d     = ctrl_q;
				if (wr_ctrl)
					ctrl_d = urct_ctrl_s'(wb);
				ctrl_d.rsv = 2'b00;
				ctrl_d.tf  = ctrl_d.tf | wrap;
				if (capture | ext_rld)
					ctrl_d.exf = 1'b1;
				else if (wrap & ~cap_mode)
					ctrl_d.exf = ~ctrl_q.exf;
			end

			always_comb
			begin
				cfg_d     = cfg_q;
				if (wr_cfg)
					cfg_d = urct_cfg_s'(wb);
				cfg_d.rsv = 3'b000;
				// On the first and third instance only, toggle on each wrap while the output is enabled, or forced by a write
				if (!HAS_TOG)
					cfg_d.tog = 1'b0;
				else if (wrap & cfg_q.oe & ~wr_cfg)
					cfg_d.tog = ~cfg_q.tog;
			end

			// ************************************************************
			// Registers
			// ************************************************************
			// Software writes are merged in the next-state logic, so each block only copies
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ctrl_q <= urct_ctrl_s'(CTRL_RST);
					cfg_q  <= urct_cfg_s'(CFG_RST);
				end
				else
				begin
					ctrl_q <= ctrl_d;
					cfg_q  <= cfg_d;
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_q <= CNT_RST;
					rld_q <= RLD_RST;
				end
				else
				begin
					cnt_q <= cnt_d;
					rld_q <= rld_d;
				end
			end

			// The event pulse is registered so consumers never see a decode glitch
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					evt_q     <= 1'b0;
					exf_req_q <= 1'b0;
				end
				else
				begin
					evt_q     <= wrap;
					exf_req_q <= exf_req_d;
				end
			end

			// ************************************************************
			// Outputs
			// ************************************************************
			// Overflow event for converter start and baud timing
			assign overflow_evt[gi]  = evt_q;
			assign toggle_out[gi]    = HAS_TOG & cfg_q.tog;
			assign toggle_out_oe[gi] = HAS_TOG & cfg_q.oe;
			// Reload-mode toggling of the external flag raises no request
			assign timer_irq_req[gi] = ctrl_q.tf | exf_req_q;

			// ************************************************************
			// Read back
			// ************************************************************
			assign rd_byte[gi] = (acc_idx == IDX_CTRL)   ? 8'(ctrl_q) :
			                     (acc_idx == IDX_CFG)    ? 8'(cfg_q) :
			                     (acc_idx == IDX_RLD_LO) ? rld_q[7:0] :
			                     (acc_idx == IDX_RLD_HI) ? rld_q[15:8] :
			                     (acc_idx == IDX_CNT_LO) ? cnt_q[7:0] :
			                                               cnt_q[15:8];
		end
	endgenerate

endmodule : urct_top

// [test/urct_top_chk.sv]
`timescale 1ns/1ps
module urct_top_chk #(
	parameter int unsigned N_TMR = urct_pkg::NUM_TMR
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  toggle_out,
	input wire logic [2:0]  toggle_out_oe,
	input wire logic [2:0]  overflow_evt,
	input wire logic [2:0]  timer_irq_req
);
	import urct_pkg::*;
	// ********
	// Decode
	// ********
	wire       acc     = psel && penable;
	wire       wr_acc  = acc && pwrite;
	wire [7:0] idx     = paddr[9:2];
	// Page 3 holds no timer
	wire       mapped  = paddr[11:10] != 2'b11 && paddr[1:0] == 2'b00 && idx >= IDX_CTRL && idx <= IDX_CNT_HI;
	wire       cfg0_wr = wr_acc && pstrb[0] && paddr == {2'b00, IDX_CFG, 2'b00};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ********
	// Checks
	// ********
	a_ready_high: assert property (acc |-> pready)
		else $error("access phase without ready");
	a_err_map: assert property (acc |-> pslverr == !mapped)
		else $error("error response does not match map");
	a_rd_byte: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0 && (mapped || prdata == 32'h0))
		else $error("read data wider than a byte");
	a_rd_stands: assert property (acc && !pwrite |=> $stable(prdata))
		else $error("read data moved after access");
	a_no_tog_one: assert property (!toggle_out[1] && !toggle_out_oe[1])
		else $error("second timer drives a toggle pin");
	a_oe_follow: assert property (cfg0_wr |=> toggle_out_oe[0] == $past(pwdata[CFG_OE_POS]))
		else $error("output enable not taken from config");
	a_tog_force: assert property (cfg0_wr |=> toggle_out[0] == $past(pwdata[CFG_TOG_POS]))
		else $error("toggle level not forced by write");
	// A wrap and a config write are the only two causes of a toggle
	a_tog_cause: assert property ($changed(toggle_out[0]) |-> overflow_evt[0] || $past(cfg0_wr))
		else $error("toggle moved without wrap");
	a_tog_wave: assert property (overflow_evt[0] && toggle_out_oe[0] && !$past(cfg0_wr) |-> $changed(toggle_out[0]))
		else $error("wrap did not toggle output");
	a_evt_flag: assert property (overflow_evt != 3'b000 |-> (timer_irq_req & overflow_evt) == overflow_evt)
		else $error("wrap without interrupt request");
	a_flag_hold: assert property (!wr_acc |=> (timer_irq_req & $past(timer_irq_req)) == $past(timer_irq_req))
		else $error("request dropped without software");
endmodule : urct_top_chk

// [test/urct_top_tb.sv]
`timescale 1ns/1ps
module urct_top_tb;
	import urct_pkg::*;
	typedef struct
	{
		string       nm;
		logic [31:0] lo;
		logic [31:0] hi;
	} urct_note_s;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [3:0]  pstrb   = 4'hf;
	logic [1:0]  ext_q   = 2'b00;
	logic [1:0]  cnt_pin = 2'b11;
	logic [1:0]  trg_pin = 2'b11;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  tog;
	logic [2:0]  tog_oe;
	logic [2:0]  evt;
	logic [2:0]  irq;
	logic [7:0]  v;
	urct_note_s  n;
	urct_note_s  q[$];
	int          fail_count = 0;
	int          cmp_count  = 0;
	// External clock at a quarter of pclk, inside its allowed range
	int          dv[4] = '{DIV_SYS12, 1, 4 * DIV_EXT8, DIV_SYS2};
	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
		ext_q <= ext_q + 2'd1;
	urct_top urct_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_osc_clk(ext_q[1]), .count_input_pin(cnt_pin),
		.external_trigger_pin(trg_pin), .toggle_out(tog), .toggle_out_oe(tog_oe),
		.overflow_evt(evt), .timer_irq_req(irq)
	);
	// ********
	// Bus tasks
	// ********
	task automatic xfer(input logic w, input int t, input logic [7:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= 12'(t * PAGE_STRIDE + 4 * i);
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input int t, input logic [7:0] i, input logic [15:0] d);
		xfer(1'b1, t, i, d[7:0]);
		if (i == IDX_RLD_LO || i == IDX_CNT_LO)
			xfer(1'b1, t, i + 8'h01, d[15:8]);
	endtask : wr
	task automatic rd(input string nm, input int t, input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi);
		q.push_back('{nm, {24'h0, lo}, {24'h0, hi}});
		xfer(1'b0, t, i, 8'h00);
	endtask : rd
	// Low then high, four cycles each: longer than the pin synchroniser needs
	task automatic pulse(input bit trg, input int i);
		repeat (2)
		begin
			@(posedge pclk);
			if (trg)
				trg_pin[i] <= ~trg_pin[i];
			else
				cnt_pin[i] <= ~cnt_pin[i];
			repeat (3) @(posedge pclk);
		end
	endtask : pulse
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// ********
	// Read monitor
	// ********
	always @(posedge pclk)
	begin
		if (psel && penable && !pwrite && pready === 1'b1)
		begin
			cmp_count++;
			n = (q.size() > 0) ? q.pop_front() : '{"no note", 32'h1, 32'h0};
			if ((prdata >= n.lo && prdata <= n.hi) !== 1'b1)
			begin
				fail_count++;
				$display("unexpected %s exp %h..%h got %h", n.nm, n.lo, n.hi, prdata);
			end
		end
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		tally_and_finish();
	end
	// ********
	// Tests
	// ********
	initial
	begin
		v = 8'($urandom(32'h992d));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int t = 0; t < 3; t++)
		begin
			for (int i = 0; i < 6; i++)
				rd("reset", t, IDX_CTRL + 8'(i), 8'h00, 8'h00);
			for (int i = 2; i < 6; i++)
			begin
				v = 8'($urandom_range(255));
				xfer(1'b1, t, IDX_CTRL + 8'(i), v);
				rd("byte", t, IDX_CTRL + 8'(i), v, v);
			end
		end
		rd("unmapped", 3, IDX_CTRL, 8'h00, 8'h00);
		wr(1, IDX_CTRL, 16'hff);
		rd("ctrl", 1, IDX_CTRL, 8'hcf, 8'hcf);
		wr(1, IDX_CTRL, 16'h00);
		$display("test registers done");
		for (int d = 0; d < 2; d++)
		begin
			trg_pin[0] <= d == 0;
			wr(0, IDX_CFG, 16'h0a | 16'(d));
			wr(0, IDX_RLD_LO, d ? 16'h00f0 : 16'hff00);
			wr(0, IDX_CNT_LO, d ? 16'h00f8 : 16'hffe0);
			wr(0, IDX_CTRL, 16'h04);
			repeat (40) @(posedge pclk);
			rd("wrap", 0, IDX_CTRL, 8'hc4, 8'hc4);
			rd("toggle", 0, IDX_CFG, 8'h0e | 8'(d), 8'h0e | 8'(d));
			rd("reloaded", 0, IDX_CNT_HI, 8'hff, 8'hff);
			wr(0, IDX_CTRL, 16'h00);
		end
		trg_pin[0] <= 1'b1;
		$display("test reload done");
		for (int c = 0; c < 2; c++)
		begin
			wr(2, IDX_CFG, 16'h00);
			wr(2, IDX_RLD_LO, 16'habcd);
			wr(2, IDX_CNT_LO, 16'h1234);
			wr(2, IDX_CTRL, 16'h08 | 16'(c));
			pulse(1, 1);
			rd("ext flag", 2, IDX_CTRL, 8'h48 | 8'(c), 8'h48 | 8'(c));
			rd("copy lo", 2, c ? IDX_RLD_LO : IDX_CNT_LO, c ? 8'h34 : 8'hcd, c ? 8'h34 : 8'hcd);
			rd("copy hi", 2, c ? IDX_RLD_HI : IDX_CNT_HI, c ? 8'h12 : 8'hab, c ? 8'h12 : 8'hab);
			wr(2, IDX_CFG, 16'h01);
			wr(2, IDX_CTRL, 16'h08 | 16'(c));
			wr(2, IDX_CNT_LO, 16'h5555);
			pulse(1, 1);
			rd("dir only", 2, IDX_CTRL, 8'h08 | 8'(c), 8'h08 | 8'(c));
			rd("no copy", 2, c ? IDX_RLD_LO : IDX_CNT_LO, c ? 8'h34 : 8'h55, c ? 8'h34 : 8'h55);
		end
		wr(2, IDX_CTRL, 16'h00);
		$display("test trigger done");
		for (int t = 0; t < 2; t++)
		begin
			wr(t, IDX_CFG, 16'h00);
			wr(t, IDX_CNT_LO, 16'h0000);
			wr(t, IDX_CTRL, 16'h06);
		end
		repeat (5) pulse(0, 0);
		for (int t = 0; t < 2; t++)
		begin
			rd("edges", t, IDX_CNT_LO, 8'h05, 8'h05);
			wr(t, IDX_CTRL, 16'h00);
		end
		$display("test counter done");
		for (int u = 0; u < 2; u++)
		begin
			trg_pin[u] <= u == 1;
			wr(1 + u, IDX_CFG, 16'h09);
			wr(1 + u, IDX_CNT_LO, u ? 16'hfffd : 16'h0003);
			wr(1 + u, IDX_CTRL, 16'h05);
			repeat (20) @(posedge pclk);
			rd("cap wrap", 1 + u, IDX_CTRL, 8'h85, 8'h85);
			rd("direction", 1 + u, IDX_CNT_HI, u ? 8'h00 : 8'hff, u ? 8'h00 : 8'hff);
			wr(1 + u, IDX_CTRL, 16'h00);
		end
		trg_pin <= 2'b11;
		$display("test direction done");
		for (int m = 0; m < 4; m++)
		begin
			wr(1, IDX_CFG, 16'(m << 3));
			wr(1, IDX_CNT_LO, 16'h0000);
			wr(1, IDX_CTRL, 16'h04);
			repeat (93) @(posedge pclk);
			wr(1, IDX_CTRL, 16'h00);
			rd("rate", 1, IDX_CNT_LO, 8'(96 / dv[m] - 1), 8'(96 / dv[m] + 1));
		end
		$display("test clock done");
		tally_and_finish();
	end
endmodule : urct_top_tb
bind urct_top urct_top_chk #(.N_TMR(N_TMR)) urct_top_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .toggle_out(toggle_out), .toggle_out_oe(toggle_out_oe),
	.overflow_evt(overflow_evt), .timer_irq_req(timer_irq_req)
);
